// ### logic/scm_pkg.sv
// package for the store-conditional monitor
// assumes a 32-bit core with word-aligned linked accesses
package scm_pkg;

    localparam int unsigned SCM_XLEN = 32;
    localparam int unsigned SCM_OFFW = 16;
    localparam int unsigned SCM_BLOCK_LSB = 4;     // tracked block 16 bytes
    localparam int unsigned SCM_REGION_LSB = 11;   // 2048-byte code region
    localparam logic [1:0] SCM_ALIGN_MASK = 2'h3;
    localparam logic [31:0] SCM_RESULT_OK = 32'h0000_0001;
    localparam logic [31:0] SCM_RESULT_FAIL = 32'h0000_0000;

    // memory access class of an access
    typedef enum logic [2:0] {
        SCM_CCA_COHERENT = 3'h1,
        SCM_CCA_NONCOH = 3'h2,
        SCM_CCA_UNCACHED = 3'h4
    } scm_cca_e;

    // one store-conditional issued by the pipeline
    typedef struct packed {
        logic [31:0] base;
        logic [15:0] offset;
        logic [31:0] data;
        logic [31:0] paddr;
        scm_cca_e cca;
        logic accel;
        logic [31:0] pc;
    } scm_sc_req_s;

    // a memory event seen on the core or the fabric
    typedef struct packed {
        logic valid;
        logic is_store;
        logic is_prefetch;
        logic is_cacheop;
        logic remote;
        scm_cca_e cca;
        logic [31:0] paddr;
    } scm_mem_evt_s;

    // word-aligned address
    function automatic logic [31:0] scm_word(input logic [31:0] a);
        return {a[31:2], 2'h0};
    endfunction : scm_word

    // same tracked block
    function automatic logic scm_same_block(input logic [31:0] a,
                                            input logic [31:0] b);
        return a[31:SCM_BLOCK_LSB] == b[31:SCM_BLOCK_LSB];
    endfunction : scm_same_block

endpackage : scm_pkg

// ### logic/scm_link_tracker.sv
// link flag and recorded address for the linked pair
// assumes events arrive one per cycle, synchronous to clock_i
`timescale 1ns/100ps
module scm_link_tracker
    import scm_pkg::*;
(
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // set and break
    input wire logic set_i,
    input wire logic [31:0] addr_i,
    input wire logic uncached_i,
    input wire logic break_i,
    // state
    output logic link_o,
    output logic [31:0] addr_o,
    output logic uncached_o
);
    logic link_q;
    logic [31:0] addr_q;
    logic unc_q;

    // ***************************************
    // link flag: a new link wins over a break
    // ***************************************
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            link_q <= 1'b0;
        end else if (set_i) begin
            link_q <= 1'b1;                 // [RULE_20]
        end else if (break_i) begin
            link_q <= 1'b0;                 // [RULE_20]
        end
    end

    // recorded address and class
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            addr_q <= 32'h0000_0000;
            unc_q <= 1'b0;
        end else if (set_i) begin
            addr_q <= scm_word(addr_i);
            unc_q <= uncached_i;
        end
    end

    assign link_o = link_q;
    assign addr_o = addr_q;
    assign uncached_o = unc_q;
endmodule : scm_link_tracker

// ### logic/scm_store_conditional.sv
// store-conditional execution and link-break monitoring
// assumes the pipeline holds sc_req until sc_ack and the memory side
// answers each forwarded store within its own time
// also assumes pc_i follows the retiring instruction stream
// a single link is tracked; a second load-linked replaces the first
`timescale 1ns/100ps
// Functional notes
// RULE_01 - intact link stores word, result one
// RULE_02 - broken link: no store, result zero
// RULE_03 - remote coherent store to block breaks
// RULE_04 - strict mode: own store breaks link
// RULE_05 - exception return breaks, keep-link variant not
// RULE_06 - aligned address must match linked address
// RULE_07 - strict mode: own load keeps link
// RULE_08 - other-block access, prefetch may break
// RULE_09 - cache operations may break link
// RULE_10 - strict mode gives defined outcome always
// RULE_11 - uncached pair needs synchronizable address
// RULE_12 - uncached: local fail only, monitor decides
// RULE_13 - own uncached store to address breaks
// RULE_14 - monitor may fail on remote stores
// RULE_15 - pause after uncached link is no-op
// RULE_16 - accelerated store closes matching gathering
// RULE_17 - low address bits nonzero: address error
// RULE_18 - address is base plus signed offset
// RULE_19 - multiprocessor atomicity needs coherent accesses
// RULE_20 - one link flag and recorded address
module scm_store_conditional
    import scm_pkg::*;
(
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // configuration
    input wire logic strict_link_break_cfg_i,
    input wire logic uncached_linked_support_cfg_i,
    // pipeline events
    input wire logic load_linked_i,
    input wire logic [31:0] load_linked_paddr_i,
    input wire scm_cca_e load_linked_cca_i,
    input wire logic exception_return_i,
    input wire logic exception_return_keep_link_i,
    input wire logic pause_i,
    input wire logic [31:0] pc_i,
    input wire scm_mem_evt_s mem_evt_i,
    // store-conditional request
    input wire logic sc_valid_i,
    input wire scm_sc_req_s sc_req_i,
    output logic sc_ack_o,
    output logic [31:0] source_result_register_o,
    output logic addr_error_o,
    output logic bus_error_o,
    output logic pause_nop_o,
    // store to memory
    output logic mem_wr_valid_o,
    output logic [31:0] mem_wr_addr_o,
    output logic [31:0] mem_wr_data_o,
    output logic mem_wr_monitored_o,
    output logic gather_close_o,
    input wire logic [31:0] gather_addr_i,
    input wire logic gather_active_i,
    // uncached monitor answer
    input wire logic monitor_done_i,
    input wire logic monitor_ok_i,
    input wire logic monitor_bus_error_i
);
    // ***************************************
    // state and internal signals
    // ***************************************
    // states: idle, waiting on the external monitor, and the
    // one-cycle turnaround after an answer, in which new requests
    // are ignored so the pipeline sees a clean acknowledge pulse
    typedef enum logic [2:0] {
        SCM_IDLE = 3'h1,
        SCM_WAIT_MON = 3'h2,
        SCM_DONE = 3'h4
    } scm_state_e;

    // sequence state
    scm_state_e state_q;
    // link state from the tracker and this cycle's decode
    logic link;
    logic unc_link;
    logic [31:0] link_addr;
    logic brk;
    logic [31:0] ea;
    logic ll_unc;
    // code-region tracking
    logic [31:0] region_pc_q;
    logic region_bad_q;
    // answer to the pipeline
    logic [31:0] result_q;
    logic ack_q;
    logic aerr_q;
    logic berr_q;
    // store towards memory
    logic wr_q;
    logic mon_q;
    logic [31:0] wr_addr_q;
    logic [31:0] wr_data_q;
    logic gclose_q;
    // local pass decision
    logic go_ok;

    // address error test, shared by the control, result and write paths
    // so all three agree on which requests are refused
    function automatic logic scm_misaligned(input logic [31:0] a);
        return (a[1:0] & SCM_ALIGN_MASK) != 2'h0;
    endfunction : scm_misaligned

    // ***************************************
    // address and link-break decode
    // ***************************************
    // effective address from base and sign-extended offset
    // only its low two bits are used here; matching uses paddr
    assign ea = sc_req_i.base +
        {{(SCM_XLEN - SCM_OFFW){sc_req_i.offset[SCM_OFFW-1]}},
         sc_req_i.offset};                  // [RULE_18]
    // class of the load-linked decides whether the pair is uncached
    assign ll_unc = (load_linked_cca_i == SCM_CCA_UNCACHED);

    // any break event; loads to the block never break, in either mode,
    // which keeps the strict behaviour and is allowed otherwise
    // the decode is combinational so an event in the same cycle as the
    // store-conditional already fails it; the cost is one more level
    // of logic in front of the write enable
    always_comb begin
        brk = 1'b0;
        if (exception_return_i && !exception_return_keep_link_i) begin
            brk = 1'b1;                     // [RULE_05]
        end
        if (mem_evt_i.valid) begin
            if (mem_evt_i.remote && mem_evt_i.is_store &&
                mem_evt_i.cca == SCM_CCA_COHERENT &&
                scm_same_block(mem_evt_i.paddr, link_addr)) begin
                brk = 1'b1;                 // [RULE_03] [RULE_19]
            end
            if (!mem_evt_i.remote && mem_evt_i.is_store &&
                scm_same_block(mem_evt_i.paddr, link_addr)) begin
                brk = 1'b1;                 // [RULE_04] [RULE_08] [RULE_13]
            end
            if (!mem_evt_i.remote && mem_evt_i.is_prefetch) begin
                brk = 1'b1;                 // [RULE_08]
            end
            if (mem_evt_i.is_cacheop &&
                (!mem_evt_i.remote ||
                 mem_evt_i.cca == SCM_CCA_COHERENT)) begin
                brk = 1'b1;                 // [RULE_09]
            end
        end
    end

    // link state
    // the tracker keeps the flag and the word address; a new
    // load-linked wins over a break in the same cycle
    scm_link_tracker u_link (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .set_i(load_linked_i),
        .addr_i(load_linked_paddr_i),
        .uncached_i(ll_unc),
        .break_i(brk),
        .link_o(link),
        .addr_o(link_addr),
        .uncached_o(unc_link)
    );                                      // [RULE_07] [RULE_20]

    // ***************************************
    // code-region check
    // ***************************************
    // a sequence leaving the 2048-byte region fails, which is permitted
    // limitation: the region is anchored at the load-linked, not a
    // sliding window, so a short unaligned sequence may still fail
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            region_pc_q <= 32'h0000_0000;
            region_bad_q <= 1'b0;
        end else if (load_linked_i) begin
            region_pc_q <= pc_i;
            region_bad_q <= 1'b0;
        end else if (pc_i[31:SCM_REGION_LSB] !=
                     region_pc_q[31:SCM_REGION_LSB]) begin
            region_bad_q <= 1'b1;           // [RULE_08]
        end
    end

    // local pass: link held, address match, legal class, region kept
    // an uncached link never pairs with a cached store-conditional,
    // and uncached pairs need the support bit as well
    assign go_ok = link && !brk && !region_bad_q &&
        scm_word(sc_req_i.paddr) == link_addr &&                // [RULE_06]
        (unc_link == (sc_req_i.cca == SCM_CCA_UNCACHED)) &&     // [RULE_11]
        (!unc_link || uncached_linked_support_cfg_i);           // [RULE_10]

    // ***************************************
    // sequence control
    // ***************************************
    // one request at a time; only an uncached pass waits for the monitor
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= SCM_IDLE;
        end else begin
            unique case (state_q)
                SCM_IDLE: begin
                    if (sc_valid_i && !scm_misaligned(ea) && go_ok &&
                        unc_link) begin
                        state_q <= SCM_WAIT_MON;    // [RULE_12]
                    end else if (sc_valid_i) begin
                        state_q <= SCM_DONE;
                    end
                end
                // no timeout: every forwarded store gets an answer
                SCM_WAIT_MON: begin
                    if (monitor_done_i) begin
                        state_q <= SCM_DONE;
                    end
                end
                SCM_DONE: begin
                    // turnaround cycle; sc_valid_i is ignored here
                    state_q <= SCM_IDLE;
                end
                default: state_q <= SCM_IDLE;
            endcase
        end
    end

    // result, acknowledge and exceptions
    // error and acknowledge are pulses; the result word holds until
    // the next request, like the register that it stands for
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            result_q <= SCM_RESULT_FAIL;
            ack_q <= 1'b0;
            aerr_q <= 1'b0;
            berr_q <= 1'b0;
        end else begin
            ack_q <= 1'b0;
            aerr_q <= 1'b0;
            berr_q <= 1'b0;
            if (state_q == SCM_IDLE && sc_valid_i) begin
                if (scm_misaligned(ea)) begin
                    aerr_q <= 1'b1;                 // [RULE_17]
                    ack_q <= 1'b1;
                end else if (!(go_ok && unc_link)) begin
                    // cached, or any local fail: outcome is final; defined in both modes
                    result_q <= go_ok ? SCM_RESULT_OK
                                      : SCM_RESULT_FAIL; // [RULE_01] [RULE_02]
                    ack_q <= 1'b1;
                end
            end else if (state_q == SCM_WAIT_MON && monitor_done_i) begin
                // the monitor alone grants uncached success
                result_q <= (monitor_ok_i && !monitor_bus_error_i)
                    ? SCM_RESULT_OK : SCM_RESULT_FAIL;  // [RULE_12] [RULE_14]
                berr_q <= monitor_bus_error_i;          // [RULE_11]
                ack_q <= 1'b1;
            end
        end
    end

    // ***************************************
    // memory write path
    // ***************************************
    // the monitored flag routes the store to the external monitor
    // instead of completing it; address and data hold after the pulse
    // so a slow consumer can still read them
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            wr_q <= 1'b0;
            mon_q <= 1'b0;
            wr_addr_q <= 32'h0000_0000;
            wr_data_q <= 32'h0000_0000;
            gclose_q <= 1'b0;
        end else begin
            wr_q <= 1'b0;
            gclose_q <= 1'b0;
            if (state_q == SCM_IDLE && sc_valid_i && !scm_misaligned(ea) &&
                go_ok) begin
                wr_q <= 1'b1;                       // [RULE_01]
                mon_q <= unc_link;                  // [RULE_12]
                wr_addr_q <= scm_word(sc_req_i.paddr);
                wr_data_q <= sc_req_i.data;
                // never gathered; flush a gather at the same word
                gclose_q <= sc_req_i.accel && gather_active_i &&
                    scm_word(gather_addr_i) ==
                    scm_word(sc_req_i.paddr);       // [RULE_16]
            end
        end
    end

    // ***************************************
    // outputs
    // ***************************************
    // pause after uncached link retires as a no-op
    assign pause_nop_o = pause_i && link && unc_link; // [RULE_15]

    // registered outputs straight from their flops
    assign sc_ack_o = ack_q;
    assign source_result_register_o = result_q;
    assign addr_error_o = aerr_q;
    assign bus_error_o = berr_q;
    assign mem_wr_valid_o = wr_q;
    assign mem_wr_addr_o = wr_addr_q;
    assign mem_wr_data_o = wr_data_q;
    assign mem_wr_monitored_o = mon_q;
    assign gather_close_o = gclose_q;
endmodule : scm_store_conditional

// ### testbench/scm_store_conditional_properties.sv
// checker on the store-conditional monitor ports
// assumes one clock domain; the bind at the foot attaches it to every scm_store_conditional instance
`timescale 1ns/100ps
module scm_store_conditional_properties
    import scm_pkg::*;
(
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // watched inputs
    input wire logic monitor_done_i,
    input wire logic monitor_ok_i,
    input wire logic monitor_bus_error_i,
    input wire logic gather_active_i,
    input wire logic [31:0] gather_addr_i,
    // watched outputs
    input wire logic sc_ack_o,
    input wire logic [31:0] source_result_register_o,
    input wire logic addr_error_o,
    input wire logic bus_error_o,
    input wire logic mem_wr_valid_o,
    input wire logic [31:0] mem_wr_addr_o,
    input wire logic mem_wr_monitored_o,
    input wire logic gather_close_o
);
    // ********************
    // port relations
    // ********************
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);
    // result decodes, shared by several properties
    logic ok_w;
    logic fail_w;
    assign ok_w = source_result_register_o == SCM_RESULT_OK;
    assign fail_w = source_result_register_o == SCM_RESULT_FAIL;
    property p_cached_ok;
        mem_wr_valid_o && !mem_wr_monitored_o |-> sc_ack_o && ok_w;
    endproperty
    a_cached_ok: assert property (p_cached_ok)
        else $error("cached write without success");
    property p_fail_nowr;
        sc_ack_o && fail_w && !addr_error_o |-> !mem_wr_valid_o;
    endproperty
    a_fail_nowr: assert property (p_fail_nowr)
        else $error("failed store still wrote");
    // success needs a local write or a monitor approval just before
    property p_no_local_ok;
        sc_ack_o && ok_w && !addr_error_o |-> mem_wr_valid_o &&
            !mem_wr_monitored_o || $past(monitor_done_i && monitor_ok_i);
    endproperty
    a_no_local_ok: assert property (p_no_local_ok)
        else $error("success without cause");
    property p_mon_fail;
        monitor_done_i && !monitor_ok_i |=> sc_ack_o && fail_w;
    endproperty
    a_mon_fail: assert property (p_mon_fail)
        else $error("monitor refusal not reported");
    property p_bus_err;
        monitor_done_i |=> sc_ack_o &&
            bus_error_o == $past(monitor_bus_error_i);
    endproperty
    a_bus_err: assert property (p_bus_err)
        else $error("bus error not passed on");
    property p_addr_err;
        addr_error_o |-> sc_ack_o && !mem_wr_valid_o &&
            $stable(source_result_register_o);
    endproperty
    a_addr_err: assert property (p_addr_err)
        else $error("misaligned store mishandled");
    property p_mon_wait;
        mem_wr_valid_o && mem_wr_monitored_o |-> !sc_ack_o [*2];
    endproperty
    a_mon_wait: assert property (p_mon_wait)
        else $error("uncached answer before monitor");
    property p_gather;
        gather_close_o |-> mem_wr_valid_o && gather_active_i &&
            mem_wr_addr_o[31:2] == gather_addr_i[31:2];
    endproperty
    a_gather: assert property (p_gather)
        else $error("gathering closed wrongly");
endmodule : scm_store_conditional_properties

bind scm_store_conditional scm_store_conditional_properties chk_i (.*);

// ### testbench/scm_monitor_model.sv
// far-side model: external monitor for uncached linked pairs
// assumes forwarded writes arrive as one-cycle pulses on clock_i
`timescale 1ns/100ps
module scm_monitor_model (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // forwarded store and test controls
    input wire logic wr_i,
    input wire logic fail_i,
    input wire logic nosync_i,
    input wire logic [3:0] wait_i,
    // answer
    output logic done_o,
    output logic ok_o,
    output logic berr_o
);
    logic [3:0] cnt_q;
    logic busy_q;
    logic ok_q;
    // wait a set time, then answer once
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_q <= 4'h0;
            busy_q <= 1'b0;
            done_o <= 1'b0;
            ok_q <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (wr_i) begin
                busy_q <= 1'b1;
                cnt_q <= wait_i;
            end else if (busy_q && cnt_q != 4'h0) begin
                cnt_q <= cnt_q - 4'h1;
            end else if (busy_q) begin
                busy_q <= 1'b0;
                done_o <= 1'b1;
                ok_q <= !fail_i && !nosync_i;
            end
        end
    end
    // flags are junk outside done so nobody relies on stale values
    assign ok_o = done_o ? ok_q : ~ok_q;
    assign berr_o = done_o ? nosync_i : ~nosync_i;
endmodule : scm_monitor_model

// ### testbench/scm_store_conditional_tb_top.sv
// testbench for the store-conditional monitor
// assumes the monitor model in its own file; strict mode not needed
`timescale 1ns/100ps
module scm_store_conditional_tb_top
    import scm_pkg::*;
;
    // ********************
    // stimulus and wiring
    // ********************
    logic clock_i = 1'b0, rst_i = 1'b1, pause_i = 1'b0, sc_valid_i = 1'b0;
    logic strict_link_break_cfg_i = 1'b1, uncached_linked_support_cfg_i = 1'b0;
    logic load_linked_i = 1'b0, gather_active_i = 1'b0;
    logic exception_return_i = 1'b0, exception_return_keep_link_i = 1'b0;
    logic [31:0] load_linked_paddr_i = 32'h0, gather_addr_i = 32'h0;
    logic [31:0] pc_i = 32'h0000_0400;
    scm_cca_e load_linked_cca_i = SCM_CCA_COHERENT;
    scm_mem_evt_s mem_evt_i = '0;
    scm_sc_req_s sc_req_i = '0;
    logic sc_ack_o, addr_error_o, bus_error_o, pause_nop_o, gather_close_o;
    logic [31:0] source_result_register_o, mem_wr_addr_o, mem_wr_data_o;
    logic mem_wr_valid_o, mem_wr_monitored_o;
    logic monitor_done_i, monitor_ok_i, monitor_bus_error_i;
    logic mon_fail = 1'b0, mon_nosync = 1'b0;
    logic [3:0] mon_wait = 4'h0;
    int mismatches = 0, cmp_count = 0;
    logic sw, sm, sg, ae, be;
    // bit 4 expected success, low bits the event between the pair
    logic [4:0] rows [10] = '{5'h10, 5'h01, 5'h02, 5'h03, 5'h14, 5'h15,
                              5'h06, 5'h07, 5'h08, 5'h09};
    always #2.5 clock_i = ~clock_i;
    scm_store_conditional uut (.*);
    scm_monitor_model far (.clock_i(clock_i), .rst_i(rst_i),
        .wr_i(mem_wr_valid_o & mem_wr_monitored_o), .fail_i(mon_fail),
        .nosync_i(mon_nosync), .wait_i(mon_wait), .done_o(monitor_done_i),
        .ok_o(monitor_ok_i), .berr_o(monitor_bus_error_i));
    task automatic chk(input string n, input logic [31:0] s, e);
        cmp_count++;
        if (s !== e) begin
            mismatches++;
            $display("[FAIL] %s exp %h got %h", n, e, s);
        end
    endtask : chk
    task automatic ll(input logic [31:0] a, input scm_cca_e c);
        @(posedge clock_i);
        load_linked_i <= 1'b1;
        load_linked_paddr_i <= a;
        load_linked_cca_i <= c;
        @(posedge clock_i);
        load_linked_i <= 1'b0;
    endtask : ll
    // one event cycle; 0 none, 1 remote store, 2 own store, 3/4 returns,
    // 5 own load, 6 none, 7 prefetch, 8/9 local and remote cache ops
    task automatic go(input logic [3:0] k, input scm_cca_e c);
        scm_mem_evt_s e;
        e = '0;
        e.valid = k inside {4'h1, 4'h2, 4'h5, 4'h7, 4'h8, 4'h9};
        e.is_store = k < 4'h3;
        e.remote = k inside {4'h1, 4'h9};
        e.is_prefetch = k == 4'h7;
        e.is_cacheop = k inside {4'h8, 4'h9};
        e.cca = c;
        e.paddr = (k == 4'h1) ? 32'h0000_1008 : 32'h0000_1000;
        @(posedge clock_i);
        mem_evt_i <= e;
        exception_return_i <= k inside {4'h3, 4'h4};
        exception_return_keep_link_i <= k == 4'h4;
        @(posedge clock_i);
        mem_evt_i <= '0;
        exception_return_i <= 1'b0;
        exception_return_keep_link_i <= 1'b0;
    endtask : go
    task automatic sc(input logic [31:0] b, input logic [15:0] o,
                      input scm_cca_e c);
        int n;
        logic [31:0] ea;
        ea = b + {{16{o[15]}}, o};
        {sw, sm, sg} = 3'h0;
        n = 0;
        @(posedge clock_i);
        sc_req_i <= '{b, o, 32'hc0de_0000 ^ ea, ea, c,
                      c == SCM_CCA_UNCACHED, pc_i};
        sc_valid_i <= 1'b1;
        do begin
            @(posedge clock_i);
            n++;
            sw |= mem_wr_valid_o;
            sm |= mem_wr_valid_o & mem_wr_monitored_o;
            sg |= gather_close_o;
        end while (sc_ack_o !== 1'b1 && n < 40);
        sc_valid_i <= 1'b0;
        ae = addr_error_o;
        be = bus_error_o;
        chk("ack", sc_ack_o, 1'b1);
        if (sw && !sm) begin
            chk("wr addr", mem_wr_addr_o, {ea[31:2], 2'h0});
            chk("wr data", mem_wr_data_o, 32'hc0de_0000 ^ ea);
        end
        repeat (2) @(posedge clock_i);
    endtask : sc
    task results;
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : results
    // ********************
    // test sequence
    // ********************
    initial begin
        repeat (6) @(posedge clock_i);
        rst_i <= 1'b0;
        @(posedge clock_i);
        chk("rst ack", sc_ack_o, 1'b0);
        chk("rst wr", mem_wr_valid_o, 1'b0);
        sc(32'h0000_1000, 16'h0, SCM_CCA_COHERENT);
        chk("no link", source_result_register_o, SCM_RESULT_FAIL);
        // both strict settings give the same outcome in this design
        for (int s = 0; s < 2; s++) begin
            strict_link_break_cfg_i <= s[0];
            foreach (rows[i]) begin
                ll(32'h0000_1000, SCM_CCA_COHERENT);
                go(rows[i][3:0], SCM_CCA_COHERENT);
                sc((rows[i][3:0] == 4'h6) ? 32'h0000_1014 : 32'h0000_1010,
                   16'hfff0, SCM_CCA_COHERENT);
                chk("row", source_result_register_o, rows[i][4]);
                chk("row wr", sw, rows[i][4]);
            end
        end
        // reset in mid-sequence must drop the link
        ll(32'h0000_1000, SCM_CCA_COHERENT);
        rst_i <= 1'b1;
        repeat (2) @(posedge clock_i);
        rst_i <= 1'b0;
        @(posedge clock_i);
        chk("mid rst ack", sc_ack_o, 1'b0);
        sc(32'h0000_1000, 16'h0, SCM_CCA_COHERENT);
        chk("rst lk", source_result_register_o, SCM_RESULT_FAIL);
        // leaving the 2048-byte code region fails the pair
        ll(32'h0000_1000, SCM_CCA_COHERENT);
        pc_i <= 32'h0000_0c00;
        sc(32'h0000_1000, 16'h0, SCM_CCA_COHERENT);
        chk("region", source_result_register_o, SCM_RESULT_FAIL);
        pc_i <= 32'h0000_0400;
        // pause under a cached link is not a no-op; then misaligned pair
        ll(32'h0000_1000, SCM_CCA_COHERENT);
        pause_i <= 1'b1;
        @(posedge clock_i);
        chk("pause run", pause_nop_o, 1'b0);
        pause_i <= 1'b0;
        sc(32'h0000_1000, 16'h0002, SCM_CCA_COHERENT);
        chk("addr err", ae, 1'b1);
        chk("misal wr", sw, 1'b0);
        // uncached pass with slow monitor and open gathering
        uncached_linked_support_cfg_i <= 1'b1;
        gather_active_i <= 1'b1;
        gather_addr_i <= 32'h0000_1000;
        mon_wait <= 4'h6;
        ll(32'h0000_1000, SCM_CCA_UNCACHED);
        pause_i <= 1'b1;
        @(posedge clock_i);
        chk("pause nop", pause_nop_o, 1'b1);
        pause_i <= 1'b0;
        sc(32'h0000_1000, 16'h0, SCM_CCA_UNCACHED);
        chk("unc res", source_result_register_o, SCM_RESULT_OK);
        chk("unc fwd", sm, 1'b1);
        chk("gather", sg, 1'b1);
        gather_active_i <= 1'b0;
        mon_wait <= 4'h0;
        // monitor refusal, then unsynchronizable address
        for (int j = 0; j < 2; j++) begin
            mon_fail <= j == 0;
            mon_nosync <= j == 1;
            ll(32'h0000_1000, SCM_CCA_UNCACHED);
            sc(32'h0000_1000, 16'h0, SCM_CCA_UNCACHED);
            chk("mon", source_result_register_o, SCM_RESULT_FAIL);
            chk("bus err", be, j[0]);
        end
        mon_nosync <= 1'b0;
        ll(32'h0000_1000, SCM_CCA_UNCACHED);
        go(4'h2, SCM_CCA_UNCACHED);
        sc(32'h0000_1000, 16'h0, SCM_CCA_UNCACHED);
        chk("own unc", source_result_register_o, SCM_RESULT_FAIL);
        chk("local fail", sm, 1'b0);
        // without uncached support the pair fails locally
        uncached_linked_support_cfg_i <= 1'b0;
        ll(32'h0000_1000, SCM_CCA_UNCACHED);
        sc(32'h0000_1000, 16'h0, SCM_CCA_UNCACHED);
        chk("uls res", source_result_register_o, SCM_RESULT_FAIL);
        chk("uls fwd", sm, 1'b0);
        results();
    end
    // about 270 cycles expected; 2000 leaves ample margin
    initial begin
        #10000;
        mismatches++;
        results();
    end
endmodule : scm_store_conditional_tb_top
